// ===== include/s71_pkg.sv
// shared constants and types of the 7:1 serializer and 1:7 deserializer
package s71_pkg;

	// ----------------------------------------------------------------
	// clocking and word sequencing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 25000; // system clock period, 40 MHz
	localparam int BITS_PER_LINE = 7;     // serial bits of one word on one line
	localparam int DATA_PER_LINE = 6;     // user bits per line in balanced mode
	localparam int LINES_PER_SLICE = 4;   // lines of one slice
	localparam logic [2:0] PHASE_A = 3'h0;    // first word of a pair is taken
	localparam logic [2:0] PHASE_B = 3'h3;    // second word of a pair is taken
	localparam logic [2:0] PHASE_LAST = 3'h6; // seven cycles carry two words

	// forwarded clock, one bit per bit time over two words: four high, three low
	localparam logic [13:0] FWD_PATTERN = 14'h078f;

	// value of the balance bit when a group holds three ones and three zeros
	localparam logic BAL_TIE = 1'b0;

	// ----------------------------------------------------------------
	// receive clock phase shift setting
	// ----------------------------------------------------------------
	localparam int FWD_PERIOD_PS = CLK_PERIOD_PS * 7 / 2; // word period
	localparam int SETUP_PS = 1500;   // input setup time
	localparam int HOLD_PS = -900;    // input hold time
	localparam int PHASE_SCALE = 256; // full period of the shift dial
	localparam int EYE_SHIFT_PS = FWD_PERIOD_PS / 4 + (SETUP_PS - HOLD_PS) / 2;
	localparam logic [7:0] PHASE_SHIFT = 8'(EYE_SHIFT_PS * PHASE_SCALE / FWD_PERIOD_PS);

	// ----------------------------------------------------------------
	// receive fifo and framing
	// ----------------------------------------------------------------
	localparam int FIFO_DEPTH = 16;
	localparam logic [2:0] RX_CNT_IDLE = 3'h7; // no word in progress

	typedef enum logic
	{
		S71_RX_HUNT = 1'b0,
		S71_RX_LOCK = 1'b1
	} s71_rx_state_t;

endpackage

// ===== rtl/s71_bal_enc.sv
// dc balance bit for one line's six-bit serial group
`timescale 1ns/1ps
`default_nettype none
module s71_bal_enc
	import s71_pkg::*;
(
	input  wire logic [5:0] group,
	output logic            bal
);

	// --------------------------------------------------------------
	// count the ones and pick the bit that pulls the line to balance
	// --------------------------------------------------------------
	always_comb
	begin
		logic [2:0] ones;
		ones = 3'h0;
		for (int i = 0; i < 6; i++)
		begin
			ones = ones + {2'h0, group[i]};
		end
		if (ones > 3'h3)
		begin
			bal = 1'b0;
		end
		else if (ones < 3'h3)
		begin
			bal = 1'b1;
		end
		else
		begin
			bal = BAL_TIE;
		end
	end

endmodule
`default_nettype wire

// ===== rtl/s71_fifo.sv
// shallow receive fifo with registered head and fill-level flags
`timescale 1ns/1ps
`default_nettype none
module s71_fifo
	import s71_pkg::*;
#(
	parameter int WIDTH = 28,
	parameter int DEPTH = FIFO_DEPTH,
	parameter int AW    = $clog2(DEPTH)
)
(
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic             wr_valid,
	input  wire logic [WIDTH-1:0] wr_data,
	output logic                  wr_ready,
	input  wire logic             rd_ready,
	output logic                  rd_valid,
	output logic [WIDTH-1:0]      rd_data,
	output logic                  lvl_quarter,
	output logic                  lvl_half,
	output logic                  lvl_three_q
);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wptr;
	logic [AW-1:0]    rptr;
	logic [AW:0]      count;
	logic [AW:0]      next_count;
	logic             push;
	logic             pop;

	// --------------------------------------------------------------
	// handshakes: refuse writes when full, refill head when free
	// --------------------------------------------------------------
	assign wr_ready = (count != (AW+1)'(DEPTH));
	assign push = wr_valid && wr_ready;
	assign pop = (count != '0) && (!rd_valid || rd_ready);
	assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);

	// storage array, written only on accepted words
	always_ff @(posedge clk)
	begin
		if (push)
		begin
			mem[wptr] <= wr_data;
		end
	end

	// pointers and fill count
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			wptr <= '0;
			rptr <= '0;
			count <= '0;
		end
		else
		begin
			wptr <= push ? wptr + AW'(1) : wptr;
			rptr <= pop ? rptr + AW'(1) : rptr;
			count <= next_count;
		end
	end

	// registered head word for the reading logic
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			rd_valid <= 1'b0;
			rd_data <= '0;
		end
		else if (pop)
		begin
			rd_valid <= 1'b1;
			rd_data <= mem[rptr];
		end
		else if (rd_ready)
		begin
			rd_valid <= 1'b0;
		end
	end

	// fill-level flags at a quarter, a half and three quarters
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			lvl_quarter <= 1'b0;
			lvl_half <= 1'b0;
			lvl_three_q <= 1'b0;
		end
		else
		begin
			lvl_quarter <= next_count >= (AW+1)'(DEPTH / 4);
			lvl_half <= next_count >= (AW+1)'(DEPTH / 2);
			lvl_three_q <= next_count >= (AW+1)'(DEPTH * 3 / 4);
		end
	end

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	property p_level_order;
		@(posedge clk) disable iff (reset)
		lvl_three_q |-> (lvl_half && lvl_quarter && count >= (AW+1)'(DEPTH * 3 / 4));
	endproperty
	a_level_order: assert property (p_level_order) else $error("fill flags disagree");

	property p_full_holds;
		@(posedge clk) disable iff (reset)
		(count == (AW+1)'(DEPTH) && !pop) |=> (count == (AW+1)'(DEPTH) && $stable(wptr));
	endproperty
	a_full_holds: assert property (p_full_holds) else $error("write taken while full");

endmodule
`default_nettype wire

// ===== rtl/s71_link.sv
// 7:1 ddr serializer and 1:7 deserializer slices with forwarded clock framing
`timescale 1ns/1ps
`default_nettype none
module s71_link
	import s71_pkg::*;
#(
	parameter int SLICES = 1,
	parameter int DEPTH  = FIFO_DEPTH,
	parameter int LINES  = SLICES * LINES_PER_SLICE,
	parameter int WBITS  = LINES * BITS_PER_LINE
)
(
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic             bal_en,
	input  wire logic [WBITS-1:0] tx_word,
	output logic                  tx_take,
	output logic [LINES-1:0]      tx_line_rise,
	output logic [LINES-1:0]      tx_line_fall,
	output logic                  tx_fwd_rise,
	output logic                  tx_fwd_fall,
	input  wire logic [LINES-1:0] rx_line_rise,
	input  wire logic [LINES-1:0] rx_line_fall,
	input  wire logic             rx_fwd_rise,
	input  wire logic             rx_fwd_fall,
	input  wire logic             rx_rev,
	input  wire logic             rx_ready,
	output logic                  rx_valid,
	output logic [WBITS-1:0]      rx_data,
	output logic                  rx_quarter,
	output logic                  rx_half,
	output logic                  rx_three_q,
	output logic                  rx_overflow,
	output logic                  rx_locked,
	output logic [7:0]            phase_shift
);

	// ----------------------------------------------------------------
	// transmit: word phase and line coding
	// ----------------------------------------------------------------
	logic [2:0]       phase;
	logic [2:0]       next_phase;
	logic [LINES-1:0] bal;
	logic [WBITS-1:0] coded;
	logic [WBITS-1:0] hold_a;
	logic [WBITS-1:0] hold_b;
	logic [WBITS-1:0] cur_a;
	logic [WBITS-1:0] cur_b;
	logic [13:0]      stream [LINES];
	logic [3:0]       pair_idx;

	// seven bit-clock cycles carry two words, so the word clock is 3.5x slower
	assign next_phase = (phase == PHASE_LAST) ? PHASE_A : phase + 3'h1;

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			phase <= PHASE_A;
		end
		else
		begin
			phase <= next_phase;
		end
	end

	// take strobe is high in the cycle a word is sampled
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			tx_take <= 1'b0;
		end
		else
		begin
			tx_take <= (next_phase == PHASE_A) || (next_phase == PHASE_B);
		end
	end

	// per line: plain seven bits, or six user bits and a balance bit
	for (genvar l = 0; l < LINES; l++)
	begin : g_code
		s71_bal_enc u_bal
		(
			.group (tx_word[l*DATA_PER_LINE +: DATA_PER_LINE]),
			.bal   (bal[l])
		);

		always_comb
		begin
			if (bal_en)
			begin
				coded[l*BITS_PER_LINE +: DATA_PER_LINE] =
					tx_word[l*DATA_PER_LINE +: DATA_PER_LINE];
				coded[l*BITS_PER_LINE + DATA_PER_LINE] = bal[l];
			end
			else
			begin
				coded[l*BITS_PER_LINE +: BITS_PER_LINE] =
					tx_word[l*BITS_PER_LINE +: BITS_PER_LINE];
			end
		end
	end

	// the two words of a pair, held for the cycles that send them
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			hold_a <= '0;
			hold_b <= '0;
		end
		else
		begin
			if (phase == PHASE_A)
			begin
				hold_a <= coded;
			end
			if (phase == PHASE_B)
			begin
				hold_b <= coded;
			end
		end
	end

	// a word is used in the same cycle it is taken, so the first pair is not late
	assign cur_a = (phase == PHASE_A) ? coded : hold_a;
	assign cur_b = (phase == PHASE_B) ? coded : hold_b;
	assign pair_idx = {phase, 1'b0};

	// per-line 14-bit serial stream of one word pair, bit 0 first
	always_comb
	begin
		for (int l = 0; l < LINES; l++)
		begin
			for (int t = 0; t < BITS_PER_LINE; t++)
			begin
				stream[l][t] = cur_a[l*BITS_PER_LINE + t];
				stream[l][t + BITS_PER_LINE] = cur_b[l*BITS_PER_LINE + t];
			end
		end
	end

	// ----------------------------------------------------------------
	// transmit: ddr bit pairs and forwarded clock
	// ----------------------------------------------------------------
	// every slice shares phase and clock, so slices line up bit for bit
	for (genvar l = 0; l < LINES; l++)
	begin : g_tx_line
		always_ff @(posedge clk)
		begin
			if (reset)
			begin
				tx_line_rise[l] <= 1'b0;
				tx_line_fall[l] <= 1'b0;
			end
			else
			begin
				tx_line_rise[l] <= stream[l][pair_idx];
				tx_line_fall[l] <= stream[l][pair_idx + 4'h1];
			end
		end
	end

	// forwarded clock from the word phase: rises with bit 0 of each word
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			tx_fwd_rise <= 1'b0;
			tx_fwd_fall <= 1'b0;
		end
		else
		begin
			tx_fwd_rise <= FWD_PATTERN[pair_idx];
			tx_fwd_fall <= FWD_PATTERN[pair_idx + 4'h1];
		end
	end

	// ----------------------------------------------------------------
	// receive: framing on the forwarded clock
	// ----------------------------------------------------------------
	logic [WBITS-1:0] acc;
	logic [WBITS-1:0] next_acc;
	logic [WBITS-1:0] done_word;
	logic [WBITS-1:0] rx_word;
	logic [2:0]       cnt;
	logic [2:0]       next_cnt;
	logic             prev_fwd;
	logic             word_done;
	logic             rx_emit;
	logic             fifo_ready;
	s71_rx_state_t    rx_state;

	// walk the rising then falling bit; a clock rise restarts at bit 0
	always_comb
	begin
		logic       f;
		logic       pf;
		logic [2:0] c;
		logic [2:0] pos;
		f = 1'b0;
		pf = prev_fwd;
		c = cnt;
		pos = 3'h0;
		next_acc = acc;
		done_word = acc;
		word_done = 1'b0;
		for (int s = 0; s < 2; s++)
		begin
			f = (s == 0) ? rx_fwd_rise : rx_fwd_fall;
			if (f && !pf)
			begin
				c = 3'h0;
			end
			if (c != RX_CNT_IDLE)
			begin
				pos = rx_rev ? 3'h6 - c : c;
				for (int l = 0; l < LINES; l++)
				begin
					next_acc[l*BITS_PER_LINE + int'(pos)] =
						(s == 0) ? rx_line_rise[l] : rx_line_fall[l];
				end
				if (c == 3'h6)
				begin
					word_done = 1'b1;
					done_word = next_acc;
				end
				c = c + 3'h1;
			end
			pf = f;
		end
		next_cnt = c;
	end

	// framing state, shared by all slices through one forwarded clock
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			acc <= '0;
			cnt <= RX_CNT_IDLE;
			prev_fwd <= 1'b0;
		end
		else
		begin
			acc <= next_acc;
			cnt <= next_cnt;
			prev_fwd <= rx_fwd_fall;
		end
	end

	// completed words for the fifo
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			rx_emit <= 1'b0;
			rx_word <= '0;
		end
		else
		begin
			rx_emit <= word_done;
			rx_word <= done_word;
		end
	end

	// lock once the first forwarded clock rise has been seen
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			rx_state <= S71_RX_HUNT;
		end
		else
		begin
			unique case (rx_state)
				S71_RX_HUNT: rx_state <= (next_cnt != RX_CNT_IDLE) ? S71_RX_LOCK : S71_RX_HUNT;
				S71_RX_LOCK: rx_state <= S71_RX_LOCK;
			endcase
		end
	end

	// status flops: lock, sticky overflow, phase dial setting
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			rx_locked <= 1'b0;
			rx_overflow <= 1'b0;
			phase_shift <= 8'h00;
		end
		else
		begin
			rx_locked <= (rx_state == S71_RX_LOCK);
			rx_overflow <= rx_overflow || (rx_emit && !fifo_ready);
			phase_shift <= PHASE_SHIFT;
		end
	end

	// ----------------------------------------------------------------
	// receive: shallow fifo to the reading logic
	// ----------------------------------------------------------------
	s71_fifo #(
		.WIDTH (WBITS),
		.DEPTH (DEPTH)
	) u_fifo (
		.clk         (clk),
		.reset       (reset),
		.wr_valid    (rx_emit),
		.wr_data     (rx_word),
		.wr_ready    (fifo_ready),
		.rd_ready    (rx_ready),
		.rd_valid    (rx_valid),
		.rd_data     (rx_data),
		.lvl_quarter (rx_quarter),
		.lvl_half    (rx_half),
		.lvl_three_q (rx_three_q)
	);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_take_gap;
		@(posedge clk) disable iff (reset)
		tx_take |=> !tx_take [*2];
	endproperty
	a_take_gap: assert property (p_take_gap) else $error("words taken too close");

	property p_fwd_frame;
		@(posedge clk) disable iff (reset)
		(phase == PHASE_A) |=> (tx_fwd_rise && tx_fwd_fall) [*2]
			##1 (!tx_fwd_rise && !tx_fwd_fall) ##1 (!tx_fwd_rise && tx_fwd_fall);
	endproperty
	a_fwd_frame: assert property (p_fwd_frame) else $error("forwarded clock shape wrong");

	property p_first_pair;
		@(posedge clk) disable iff (reset)
		(phase == PHASE_A) |=> (tx_fwd_rise && tx_line_rise[0] == $past(coded[0])
			&& tx_line_fall[0] == $past(coded[1]));
	endproperty
	a_first_pair: assert property (p_first_pair) else $error("first pair misaligned");

	property p_second_word;
		@(posedge clk) disable iff (reset)
		(phase == PHASE_B) |=> (tx_line_rise[0] == $past(hold_a[6])
			&& tx_line_fall[0] == $past(coded[0]) && tx_fwd_fall);
	endproperty
	a_second_word: assert property (p_second_word) else $error("second word misaligned");

	property p_bal_data;
		@(posedge clk) disable iff (reset)
		bal_en |-> (coded[12:7] == tx_word[11:6]);
	endproperty
	a_bal_data: assert property (p_bal_data) else $error("balanced data misplaced");

	property p_bal_bit;
		@(posedge clk) disable iff (reset)
		bal_en |-> ((($countones(tx_word[5:0]) > 3) && !coded[6])
			|| (($countones(tx_word[5:0]) < 3) && coded[6])
			|| ($countones(tx_word[5:0]) == 3));
	endproperty
	a_bal_bit: assert property (p_bal_bit) else $error("balance bit wrong");

	property p_bal_tie;
		@(posedge clk) disable iff (reset)
		(bal_en && $countones(tx_word[5:0]) == 3) |-> (coded[6] == BAL_TIE);
	endproperty
	a_bal_tie: assert property (p_bal_tie) else $error("tie balance bit wrong");

	property p_rx_gap;
		@(posedge clk) disable iff (reset)
		rx_emit |=> !rx_emit [*2];
	endproperty
	a_rx_gap: assert property (p_rx_gap) else $error("words emitted too close");

	property p_rx_frame;
		@(posedge clk) disable iff (reset)
		(rx_fwd_rise && !prev_fwd && rx_fwd_fall) ##1 (rx_fwd_rise && rx_fwd_fall)
			##1 (!rx_fwd_rise && !rx_fwd_fall) |-> ##2 rx_emit;
	endproperty
	a_rx_frame: assert property (p_rx_frame) else $error("word not framed on clock");

endmodule
`default_nettype wire

// ===== verif/s71_link_tb.sv
// self-checking testbench of one link slice against the far-side model
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) check_val(64'(g), 64'(e))
module s71_link_tb
	import s71_pkg::*;
;
	logic        clk;
	logic        reset;
	logic        bal_en;
	logic [27:0] tx_word;
	logic        tx_take;
	logic [3:0]  tx_line_rise;
	logic [3:0]  tx_line_fall;
	logic        tx_fwd_rise;
	logic        tx_fwd_fall;
	logic [3:0]  rx_line_rise;
	logic [3:0]  rx_line_fall;
	logic        rx_fwd_rise;
	logic        rx_fwd_fall;
	logic        rx_rev;
	logic        rx_ready;
	logic        rx_valid;
	logic [27:0] rx_data;
	logic        rx_quarter;
	logic        rx_half;
	logic        rx_three_q;
	logic        rx_overflow;
	logic        rx_locked;
	logic [7:0]  phase_shift;
	int          num_errors;
	int          num_checks;

	// ----------------------------------------------------------------
	// clock, design and far side
	// ----------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	s71_link s71_link_inst (.clk(clk), .reset(reset), .bal_en(bal_en), .tx_word(tx_word),
		.tx_take(tx_take), .tx_line_rise(tx_line_rise), .tx_line_fall(tx_line_fall),
		.tx_fwd_rise(tx_fwd_rise), .tx_fwd_fall(tx_fwd_fall), .rx_line_rise(rx_line_rise),
		.rx_line_fall(rx_line_fall), .rx_fwd_rise(rx_fwd_rise), .rx_fwd_fall(rx_fwd_fall),
		.rx_rev(rx_rev), .rx_ready(rx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_quarter(rx_quarter), .rx_half(rx_half), .rx_three_q(rx_three_q),
		.rx_overflow(rx_overflow), .rx_locked(rx_locked), .phase_shift(phase_shift));

	s71_peer s71_peer_inst (.clk(clk), .reset(reset), .line_rise(rx_line_rise),
		.line_fall(rx_line_fall), .fwd_rise(rx_fwd_rise), .fwd_fall(rx_fwd_fall));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic check_val(input logic [63:0] got, input logic [63:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic give_up();
		check_val(64'h0, 64'h1);
		tally_and_finish();
	endtask

	// seven serial bits of one line, balance bit worked out by counting
	function automatic logic [6:0] line_bits(input logic [27:0] w, input logic bal, input int l);
		logic [6:0] g;
		int ones;
		g = bal ? {1'b0, w[6*l +: 6]} : w[7*l +: 7];
		ones = 0;
		for (int k = 0; k < 6; k++)
			ones += g[k];
		if (bal)
			g[6] = (ones > 3) ? 1'b0 : (ones < 3) ? 1'b1 : BAL_TIE;
		return g;
	endfunction

	function automatic logic [27:0] word_of(input int i);
		return 28'(32'(i + 1) * 32'h09e3_779b);
	endfunction

	task automatic next_take(output int gap);
		gap = 0;
		do
		begin
			@(negedge clk);
			gap++;
		end
		while (tx_take !== 1'b1 && gap < 20);
		if (gap >= 20)
			give_up();
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic do_reset();
		@(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		@(negedge clk);
		`CHK({phase_shift, tx_take, rx_valid, rx_overflow, rx_locked}, 12'h000);
		@(posedge clk);
		reset <= 1'b0;
		repeat (3) @(negedge clk);
		`CHK(phase_shift, (87500 / 4 + (1500 + 900) / 2) * 256 / 87500);
		`CHK(rx_locked, 1'b0);
	endtask

	// word a taken at phase 0, b three cycles later; walk both words out
	task automatic tx_pair(input logic [27:0] a, input logic [27:0] b, input logic bal);
		logic [13:0] s [4];
		logic [3:0]  r;
		logic [3:0]  f;
		int          g;
		for (int l = 0; l < 4; l++)
			s[l] = {line_bits(b, bal, l), line_bits(a, bal, l)};
		@(posedge clk);
		bal_en <= bal;
		tx_word <= a;
		next_take(g);
		next_take(g);
		if (g == 3)
			next_take(g);
		`CHK(g, 4);
		@(posedge clk);
		tx_word <= b;
		for (int i = 0; i < 7; i++)
		begin
			for (int l = 0; l < 4; l++)
			begin
				r[l] = s[l][2*i];
				f[l] = s[l][2*i+1];
			end
			@(negedge clk);
			`CHK(tx_take, (i == 2 || i == 6));
			`CHK({tx_fwd_rise, tx_fwd_fall}, {(2*i) % 7 < 4, (2*i+1) % 7 < 4});
			`CHK(tx_line_rise, r);
			`CHK(tx_line_fall, f);
		end
	endtask

	task automatic rx_expect(input logic [27:0] w, input logic rev);
		logic [27:0] e;
		int          n;
		for (int l = 0; l < 4; l++)
			for (int j = 0; j < 7; j++)
				e[7*l+j] = w[7*l + (rev ? 6 - j : j)];
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end
		while (rx_valid !== 1'b1 && n < 60);
		if (n >= 60)
			give_up();
		`CHK(rx_data, e);
		@(posedge clk);
	endtask

	// back-to-back words, a cut-short word that must vanish, then reversed order
	task automatic rx_words();
		@(negedge clk);
		s71_peer_inst.push(28'h3c6_9a5f, 7);
		s71_peer_inst.push(28'h1d2_e4b7, 7);
		s71_peer_inst.push(28'hfff_ffff, 5);
		s71_peer_inst.push(28'h0a1_b2c3, 7);
		rx_expect(28'h3c6_9a5f, 1'b0);
		rx_expect(28'h1d2_e4b7, 1'b0);
		rx_expect(28'h0a1_b2c3, 1'b0);
		repeat (10) @(negedge clk);
		`CHK({rx_valid, rx_locked}, 2'h1);
		@(posedge clk);
		rx_rev <= 1'b1;
		@(negedge clk);
		s71_peer_inst.push(28'h5e7_1c39, 7);
		rx_expect(28'h5e7_1c39, 1'b1);
		rx_rev <= 1'b0;
	endtask

	// reader stalls: fill through each level to overflow, then drain in order
	task automatic fifo_fill();
		logic [3:0] e;
		rx_ready <= 1'b0;
		for (int i = 0; i < 18; i++)
		begin
			@(negedge clk);
			s71_peer_inst.push(word_of(i), 7);
			e = (i == 4) ? 4'h2 : (i == 8) ? 4'h6 : (i == 12) ? 4'he : 4'hf;
			if (i == 4 || i == 8 || i == 12 || i == 17)
			begin
				repeat (30) @(negedge clk);
				`CHK({rx_three_q, rx_half, rx_quarter, rx_overflow}, e);
			end
		end
		@(posedge clk);
		rx_ready <= 1'b1;
		for (int i = 0; i < 17; i++)
			rx_expect(word_of(i), 1'b0);
		repeat (10) @(negedge clk);
		`CHK({rx_valid, rx_three_q, rx_half, rx_quarter, rx_overflow}, 5'h01);
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		num_errors = 0;
		num_checks = 0;
		reset = 1'b1;
		bal_en = 1'b0;
		tx_word = 28'h000_0000;
		rx_rev = 1'b0;
		rx_ready = 1'b1;
		do_reset();
		tx_pair(28'h5a5_c3f1, 28'h2b7_e015, 1'b0);
		tx_pair(28'hff8_707f, 28'h000_0000, 1'b1);
		tx_pair(28'h00b_1c5a, 28'hfff_fffe, 1'b1);
		rx_words();
		fifo_fill();
		do_reset();
		tally_and_finish();
	end
endmodule
`default_nettype wire

// ===== verif/s71_peer.sv
// far-side serializer model that drives the receive lines of the link
`timescale 1ns/1ps
`default_nettype none
module s71_peer
	import s71_pkg::*;
(
	input  wire logic  clk,
	input  wire logic  reset,
	output logic [3:0] line_rise,
	output logic [3:0] line_fall,
	output logic       fwd_rise,
	output logic       fwd_fall
);
	logic [4:0] bits_q[$]; // one entry per bit time: {clock, lines}
	logic [4:0] slot_a;
	logic [4:0] slot_b;

	// queue the first n bit times of a word, bit 0 first, clock high for bits 0..3
	function automatic void push(input logic [27:0] w, input int n);
		logic [4:0] b;
		for (int j = 0; j < n; j++)
		begin
			b[4] = (j < 4);
			for (int l = 0; l < LINES_PER_SLICE; l++)
				b[l] = w[7*l+j];
			bits_q.push_back(b);
		end
	endfunction

	// lines start quiet so the link never sees unknowns
	initial
	begin
		{line_rise, line_fall, fwd_rise, fwd_fall} = 10'h000;
		slot_b = 5'h00;
	end

	// two bit times per cycle; when idle the clock stays low and lines flip
	always @(posedge clk)
	begin
		if (reset)
		begin
			bits_q.delete();
			slot_a = 5'h00;
			slot_b = 5'h00;
		end
		else
		begin
			slot_a = (bits_q.size() > 0) ? bits_q.pop_front() : {1'b0, ~slot_b[3:0]};
			slot_b = (bits_q.size() > 0) ? bits_q.pop_front() : {1'b0, ~slot_a[3:0]};
		end
		line_rise <= slot_a[3:0];
		line_fall <= slot_b[3:0];
		fwd_rise  <= slot_a[4];
		fwd_fall  <= slot_b[4];
	end
endmodule
`default_nettype wire
